// *** itd_decoder.sv ***
// Instruction length, timing and data space target decoder with a debug halt/step gate.
`timescale 1ns/10ps
`default_nettype none
module itd_decoder
  import itd_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Opcode from fetch, same clock domain.
  input wire logic i_valid,
  input wire logic [7:0] i_opcode,
  input wire logic i_branch_taken,
  input wire logic [15:0] i_data_addr,
  input wire logic i_flash_move_en,
  // Debug requests from the serial debug link logic, same clock domain.
  input wire logic i_dbg_halt,
  input wire logic i_dbg_step,
  input wire logic i_dbg_bkpt_en,
  input wire logic [15:0] i_dbg_bkpt_addr,
  input wire logic [15:0] i_pc,
  // Decode results.
  output logic o_valid,
  output itd_decode_s o_dec,
  output logic [3:0] o_total_cycles,
  output itd_target_e o_target,
  output logic o_halted
);
  itd_decode_s dec_d;
  logic [3:0] total_d;
  itd_target_e tgt_d;
  logic halted_q;
  logic issue;

  // Combinational opcode decode; unlisted rows default to one byte and two cycles.
  always_comb begin
    dec_d = '0;
    dec_d.length = LEN_ONE;
    dec_d.cycles = CYC_DEFAULT;
    if (i_opcode[3:0] >= 4'h8 && (i_opcode[7:4] == OP_ADD || i_opcode[7:4] == OP_ADC ||
        i_opcode[7:4] == OP_SBC || i_opcode[7:4] == OP_INC)) begin
      dec_d.length = LEN_ONE;
      dec_d.cycles = CYC_ONE;
    end else if (i_opcode == 8'h04) begin
      dec_d.length = LEN_ONE;
      dec_d.cycles = CYC_ONE;
    end else if (i_opcode[3:0] == 4'h5 && (i_opcode[7:4] == OP_ADD ||
        i_opcode[7:4] == OP_ADC || i_opcode[7:4] == OP_SBC || i_opcode[7:4] == OP_INC)) begin
      dec_d.length = LEN_TWO;
      dec_d.cycles = CYC_TWO;
    end else if (i_opcode[3:1] == 3'h3 && (i_opcode[7:4] == OP_ADD ||
        i_opcode[7:4] == OP_ADC || i_opcode[7:4] == OP_SBC || i_opcode[7:4] == OP_INC)) begin
      dec_d.length = LEN_ONE;
      dec_d.cycles = CYC_TWO;
    end else if (i_opcode[3:0] == 4'h4 && (i_opcode[7:4] == OP_ADD ||
        i_opcode[7:4] == OP_ADC || i_opcode[7:4] == OP_SBC)) begin
      dec_d.length = LEN_TWO;
      dec_d.cycles = CYC_TWO;
    end else if (i_opcode == 8'h40 || i_opcode == 8'h50 || i_opcode == 8'h60 ||
        i_opcode == 8'h70) begin
      // Relative conditional jumps: 2 bytes, 2 cycles not taken, 3 taken.
      dec_d.length = LEN_TWO;
      dec_d.cycles = CYC_TWO;
      dec_d.cond_branch = 1'b1;
      dec_d.taken_extra = 1'b1;
    end else if (i_opcode == 8'h20 || i_opcode == 8'h30 || i_opcode == 8'h10 ||
        i_opcode[7:4] == 4'hb && i_opcode[3:2] != 2'h0 || i_opcode[7:3] == 5'h1b ||
        i_opcode == 8'hd5) begin
      // Bit tests, compare-jumps and decrement-jumps: 3 bytes unless register form.
      dec_d.length = (i_opcode[7:3] == 5'h1b) ? LEN_TWO : LEN_THREE;
      dec_d.cycles = (i_opcode[7:3] == 5'h1b) ? CYC_TWO : CYC_THREE;
      dec_d.cond_branch = 1'b1;
      dec_d.taken_extra = 1'b1;
    end else if (i_opcode == OP_CODE_READ_DPTR || i_opcode == OP_CODE_READ_PC) begin
      dec_d.length = LEN_ONE;
      dec_d.cycles = CYC_THREE;
      dec_d.flash_read = 1'b1;
    end else if ((i_opcode[7:4] == OP_DATA_MOVE_RD || i_opcode[7:4] == OP_DATA_MOVE_WR) &&
        (i_opcode[3:0] == 4'h0 || i_opcode[3:1] == 3'h1)) begin
      dec_d.length = LEN_ONE;
      dec_d.cycles = CYC_THREE;
      dec_d.data_move = 1'b1;
      dec_d.data_write = (i_opcode[7:4] == OP_DATA_MOVE_WR);
    end
    // Opcode bits pass untouched, so binary compatibility is kept.
  end

  // Total cycles and the data space target for this instruction.
  always_comb begin
    total_d = dec_d.cycles + ((dec_d.cond_branch && i_branch_taken) ? 4'h1 : 4'h0);
    tgt_d = TGT_NONE;
    if (dec_d.data_move) begin
      if (i_flash_move_en) begin
        tgt_d = TGT_FLASH;
      end else if (i_data_addr < ERAM_TOP) begin
        tgt_d = TGT_ERAM;
      end else begin
        tgt_d = TGT_EXTMEM;
      end
    end
  end

  // Issue gate: a halted core lets one instruction through in each cycle that i_dbg_step is high.
  assign issue = i_valid && (!halted_q || i_dbg_step);

  // Debug halt state lives in dedicated flops, never in user memory.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      halted_q <= 1'b0;
    end else if (i_dbg_halt || (i_dbg_bkpt_en && i_valid && i_pc == i_dbg_bkpt_addr)) begin
      halted_q <= 1'b1;
    end else if (!i_dbg_halt && !i_dbg_step && i_dbg_bkpt_en == 1'b0 && halted_q) begin
      halted_q <= halted_q;
    end
  end

  // Registered decode outputs to the sequencer.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_valid <= 1'b0;
      o_dec <= '0;
      o_total_cycles <= 4'h0;
      o_target <= TGT_NONE;
    end else begin
      o_valid <= issue;
      o_dec <= dec_d;
      o_total_cycles <= total_d;
      o_target <= tgt_d;
    end
  end

  assign o_halted = halted_q;

  // A register-form add must report one byte and one cycle.
  reg_timing_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode[7:3] == 5'h05) |=> (o_dec.length == 2'h1 && o_dec.cycles == 4'h1))
    else $error("register add timing wrong");
  // Direct forms fetch an address byte, so they cost a second cycle.
  direct_timing_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h25) |=> (o_dec.length == 2'h2 && o_dec.cycles == 4'h2))
    else $error("direct add timing wrong");
  // Indirect forms are one byte but need an extra cycle for the pointer read.
  indirect_timing_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h96) |=> (o_dec.length == 2'h1 && o_dec.cycles == 4'h2))
    else $error("indirect subtract timing wrong");
  // Immediate forms carry their operand byte.
  immediate_timing_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h34) |=> (o_dec.length == 2'h2 && o_dec.cycles == 4'h2))
    else $error("immediate carry add timing wrong");
  // A taken relative jump pays one cycle for the redirect.
  branch_extra_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h60 && i_branch_taken) |=> (o_total_cycles == 4'h3))
    else $error("taken branch not one cycle longer");
  // A jump that falls through costs only its byte count.
  branch_short_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h70 && !i_branch_taken) |=> (o_total_cycles == 4'h2))
    else $error("not taken branch too long");
  // The flash route overrides the address decode for a move.
  flash_move_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'hf0 && i_flash_move_en) |=> (o_target == TGT_FLASH && o_dec.data_write))
    else $error("move did not target flash");
  // Nothing issues while halted unless a step is granted.
  halt_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_halted && !i_dbg_step) |=> !o_valid)
    else $error("instruction issued while halted");
  // The accumulator increment is the pipelined one-byte one-cycle case.
  length_match_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h04) |=> (o_dec.cycles == {2'h0, o_dec.length}))
    else $error("cycles differ from length");
  // Accumulator increment reports one byte and one cycle.
  inc_acc_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h04) |=> (o_dec.length == 2'h1 && o_dec.cycles == 4'h1))
    else $error("accumulator increment timing wrong");
  // Direct increment is two bytes and two cycles.
  inc_direct_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h05) |=> (o_dec.length == 2'h2 && o_dec.cycles == 4'h2))
    else $error("direct increment timing wrong");
  // The sequencer needs both branch flags to add the taken cycle itself.
  branch_flags_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h40) |=> (o_dec.cond_branch && o_dec.taken_extra))
    else $error("branch flags missing");
  // Arithmetic never picks up a branch cycle, whatever the taken input says.
  arith_no_branch_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h28 && i_branch_taken) |=> (!o_dec.cond_branch && o_total_cycles == 4'h1))
    else $error("arithmetic took a branch cycle");
  // A code space read is a flash read with no data space target.
  code_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'h93) |=> (o_dec.flash_read && o_target == TGT_NONE))
    else $error("code space read not flagged");
  // Low addresses of a move land in the expanded on-chip RAM.
  ram_target_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'he0 && !i_flash_move_en && i_data_addr < ERAM_TOP)
    |=> (o_target == TGT_ERAM))
    else $error("move missed expanded RAM");
  // High addresses of a move go out through the external memory interface.
  ext_target_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'he2 && !i_flash_move_en && i_data_addr >= ERAM_TOP)
    |=> (o_target == TGT_EXTMEM))
    else $error("move missed external memory");
  // A read move is a data move that does not write.
  move_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'he0) |=> (o_dec.data_move && !o_dec.data_write))
    else $error("read move flags wrong");
  // Move timing is counted in plain clocks.
  move_cycles_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_opcode == 8'hf0) |=> (o_dec.cycles == CYC_THREE))
    else $error("move cycle count wrong");
  // A granted step lets the waiting opcode through.
  step_issue_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_valid && o_halted && i_dbg_step) |=> o_valid)
    else $error("step did not issue");
  // A running core passes every valid opcode at full speed.
  run_issue_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_valid && !o_halted) |=> o_valid)
    else $error("running core dropped an opcode");
  // Halt is sticky until reset; there is no resume input.
  halt_sticky_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_halted |=> o_halted)
    else $error("halt released without reset");
  // A halt request takes effect at the next edge.
  halt_entry_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_dbg_halt |=> o_halted)
    else $error("halt request ignored");
endmodule
`default_nettype wire

// *** itd_pkg.sv ***
// Package of constants and carrier types for the instruction timing decoder.
// How it works
// - Opcode map, addressing modes and flag effects match the standard instruction set.
// - All timing counts are plain system clock cycles, never machine cycles.
// - Most instructions take as many cycles as they have program bytes; here unlisted opcodes default to one byte and two cycles.
// - A not-taken conditional branch finishes one cycle before a taken one.
// - The data space move reaches expanded RAM, external memory and program flash.
// - Software reads flash by code space read or data space move, writes by move.
// - Register add, carry add, borrow subtract, increment and accumulator increment: 1 byte, 1 cycle.
// - Direct forms of those arithmetic instructions: 2 bytes, 2 cycles.
// - Indirect RAM forms of those arithmetic instructions: 1 byte, 2 cycles.
// - Immediate add, carry add and borrow subtract: 2 bytes, 2 cycles.
// - A serial link lets a host program flash and talk to debug logic.
// - Host sets breakpoints, runs, halts, steps, reads stack, registers and memory; here a halt holds until reset, with no resume.
// - Debug uses no user RAM, stack, timers or visible resources.
`default_nettype none
package itd_pkg;
  // Arithmetic group opcode high nibbles.
  localparam logic [3:0] OP_INC = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h2;
  localparam logic [3:0] OP_ADC = 4'h3;
  localparam logic [3:0] OP_SBC = 4'h9;
  // Other opcodes the decoder treats specially.
  localparam logic [7:0] OP_CODE_READ_DPTR = 8'h93;
  localparam logic [7:0] OP_CODE_READ_PC = 8'h83;
  localparam logic [3:0] OP_DATA_MOVE_RD = 4'he;
  localparam logic [3:0] OP_DATA_MOVE_WR = 4'hf;
  // Timing figures in clock cycles and instruction lengths in bytes.
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_DEFAULT = 4'h2;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // Data space move targets.
  localparam logic [15:0] ERAM_TOP = 16'h0400;

  typedef enum logic [1:0] {TGT_NONE, TGT_ERAM, TGT_EXTMEM, TGT_FLASH} itd_target_e;

  // Decode result handed to the pipeline sequencer.
  typedef struct packed {
    logic [1:0] length;
    logic [3:0] cycles;
    logic taken_extra;
    logic cond_branch;
    logic flash_read;
    logic data_move;
    logic data_write;
  } itd_decode_s;
endpackage
`default_nettype wire

// *** itd_host_model.sv ***
// Debug host model that drives halt, step and breakpoint requests.
`timescale 1ns/10ps
`default_nettype none
module itd_host_model #(
  parameter logic [15:0] BKPT_ADDR = 16'h0123
) (
  // Clock and commands from the bench.
  input wire logic i_clk,
  input wire logic i_halt_req,
  input wire logic i_step_req,
  input wire logic i_bkpt_req,
  // Debug requests toward the core.
  output logic o_dbg_halt,
  output logic o_dbg_step,
  output logic o_dbg_bkpt_en,
  output logic [15:0] o_dbg_bkpt_addr
);
  // Requests start idle so the core sees known levels from time zero.
  initial begin
    o_dbg_halt = 1'b0;
    o_dbg_step = 1'b0;
    o_dbg_bkpt_en = 1'b0;
  end
  // Requests change on the falling edge, a full half cycle before sampling.
  always @(negedge i_clk) begin
    o_dbg_halt <= i_halt_req;
    o_dbg_step <= i_step_req;
    o_dbg_bkpt_en <= i_bkpt_req;
  end
  // One fixed breakpoint address is enough for the scenarios run here.
  assign o_dbg_bkpt_addr = BKPT_ADDR;
endmodule
`default_nettype wire

// *** test_cpu_instruction_timing_decoder.sv ***
// Self-checking testbench for the instruction timing decoder.
`timescale 1ns/10ps
`default_nettype none
module test_cpu_instruction_timing_decoder;
  import itd_pkg::*;
  logic clk = 1'b0, reset = 1'b1, valid = 1'b0, taken = 1'b0, fen = 1'b0;
  logic halt_req = 1'b0, step_req = 1'b0, bkpt_req = 1'b0;
  logic [7:0] op = 8'h00;
  logic [15:0] addr = 16'h0000, pc = 16'h0000, bkpt_addr;
  logic halt, step, bkpt_en, o_valid, halted;
  itd_decode_s dec;
  logic [3:0] total;
  itd_target_e target;
  int num_errors = 0, compares = 0;
  // Design under test and the debug host beside it.
  itd_decoder i_dut (.i_clk(clk), .i_reset(reset), .i_valid(valid), .i_opcode(op),
    .i_branch_taken(taken), .i_data_addr(addr), .i_flash_move_en(fen), .i_dbg_halt(halt),
    .i_dbg_step(step), .i_dbg_bkpt_en(bkpt_en), .i_dbg_bkpt_addr(bkpt_addr), .i_pc(pc),
    .o_valid(o_valid), .o_dec(dec), .o_total_cycles(total), .o_target(target),
    .o_halted(halted));
  itd_host_model i_host (.i_clk(clk), .i_halt_req(halt_req), .i_step_req(step_req),
    .i_bkpt_req(bkpt_req), .o_dbg_halt(halt), .o_dbg_step(step), .o_dbg_bkpt_en(bkpt_en),
    .o_dbg_bkpt_addr(bkpt_addr));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ends the run with the verdict.
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Presents one opcode; its decode is settled by the next falling edge.
  task automatic send(input logic [7:0] code, input logic tk);
    valid = 1'b1;
    op = code;
    taken = tk;
    @(negedge clk);
  endtask
  // Holds reset and checks that outputs stay quiet meanwhile.
  task automatic do_reset(input int n);
    reset = 1'b1;
    valid = 1'b0;
    repeat (n) @(negedge clk);
    check(o_valid, 1'b0);
    check(halted, 1'b0);
    reset = 1'b0;
  endtask
  // Every form of the four arithmetic groups, with taken set to expose a stray extra cycle.
  task automatic arith_group();
    logic [3:0] his [4] = '{4'h0, 4'h2, 4'h3, 4'h9};
    logic [1:0] len;
    logic [3:0] cyc;
    for (int h = 0; h < 4; h++) begin
      for (int lo = 4; lo < 16; lo++) begin
        len = (lo == 5 || (lo == 4 && his[h] != 4'h0)) ? 2'h2 : 2'h1;
        cyc = (lo >= 8 || (lo == 4 && his[h] == 4'h0)) ? 4'h1 : 4'h2;
        send({his[h], 4'(lo)}, 1'b1);
        check(dec.length, len);
        check(dec.cycles, cyc);
        check(total, cyc);
      end
    end
  endtask
  // A taken conditional branch costs exactly one cycle more.
  task automatic branches();
    logic [7:0] ops [4] = '{8'h40, 8'h50, 8'h60, 8'h70};
    foreach (ops[i]) begin
      send(ops[i], 1'b0);
      check(total, 4'h2);
      send(ops[i], 1'b1);
      check(total, 4'h3);
      check(dec.cond_branch, 1'b1);
      check(dec.taken_extra, 1'b1);
    end
  endtask
  // One data space move and its expected target.
  task automatic move(input logic [7:0] code, input logic [15:0] a, input logic f,
                      input itd_target_e tg);
    addr = a;
    fen = f;
    send(code, 1'b0);
    check(target, tg);
    check(dec.data_write, code[4]);
    check(dec.data_move, 1'b1);
    check(dec.cycles, 4'h3);
  endtask
  // Flash reads by code space read and moves to all three targets.
  task automatic data_moves();
    send(8'h93, 1'b0);
    check(dec.flash_read, 1'b1);
    check(target, TGT_NONE);
    move(8'he0, 16'h03ff, 1'b0, TGT_ERAM);
    move(8'he2, 16'h0400, 1'b0, TGT_EXTMEM);
    move(8'hf0, 16'h0010, 1'b1, TGT_FLASH);
  endtask
  // Halt blocks issue, one step lets exactly one opcode through.
  task automatic debug_halt();
    halt_req <= 1'b1;
    send(8'h28, 1'b0);
    send(8'h28, 1'b0);
    check(halted, 1'b1);
    step_req <= 1'b1;
    send(8'h28, 1'b0);
    check(o_valid, 1'b0);
    check(dec.length, 2'h1);
    step_req <= 1'b0;
    halt_req <= 1'b0;
    send(8'h28, 1'b0);
    check(o_valid, 1'b1);
    send(8'h28, 1'b0);
    check(o_valid, 1'b0);
  endtask
  // A breakpoint halts only when the program counter matches.
  task automatic breakpoint();
    do_reset(2);
    bkpt_req <= 1'b1;
    pc = 16'h0100;
    send(8'h28, 1'b0);
    send(8'h28, 1'b0);
    check(o_valid, 1'b1);
    check(halted, 1'b0);
    pc = 16'h0123;
    send(8'h28, 1'b0);
    send(8'h28, 1'b0);
    check(halted, 1'b1);
    check(o_valid, 1'b0);
  endtask
  // Main sequence.
  initial begin
    do_reset(12);
    arith_group();
    branches();
    data_moves();
    debug_halt();
    breakpoint();
    wrap_up();
  end
endmodule
`default_nettype wire
